// *** design/fsb_pkg.sv ***
/*
  Shared constants for the format sequencer branch decoder: widths,
  register offsets, field positions, reset values, command codes and
  the enumerations of actions and sequencer states.
  Assumes nothing of its surroundings; imported whole by every module.
*/
package fsb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int REG_A_W = 8;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFF_BR_ADDR = 8'h78;
  localparam logic [7:0] OFF_CTRL = 8'h79;
  localparam logic [7:0] OFF_STAT = 8'h7A;
  localparam logic [7:0] OFF_SEQ = 8'h7B;
  localparam logic [7:0] OFF_START = 8'h7C;
  localparam logic [7:0] OFF_HALT_CNT = 8'h7D;
  localparam logic [7:0] OFF_SNAP = 8'h7E;

  // reset values
  localparam logic [7:0] RST_BR_ADDR = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_START = 8'h00;

  // control field positions
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;

  // status field positions
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_ACT_LSB = 1;
  localparam int STAT_CRC_TBL_BIT = 3;
  localparam int STAT_ALT_BIT = 4;

  // snapshot field positions
  localparam int SNAP_CMD_LSB = 0;
  localparam int SNAP_TBL_BIT = 3;
  localparam int SNAP_CRC_BIT = 4;
  localparam int SNAP_NE_BIT = 5;
  localparam int SNAP_MARK_BIT = 6;

  ////////////////////////////////////////////////////////////////////////
  // command codes, crc-aware table
  localparam logic [2:0] CRC_STOP_CRC = 3'b001;
  localparam logic [2:0] CRC_STOP_NE = 3'b010;
  localparam logic [2:0] CRC_STOP_NE_CRC = 3'b011;
  localparam logic [2:0] CRC_JMP_GOOD = 3'b100;
  localparam logic [2:0] CRC_JMP_CRC = 3'b101;
  localparam logic [2:0] CRC_JMP_NE = 3'b110;
  localparam logic [2:0] CRC_JMP_NE_CRC = 3'b111;

  // command codes, plain table
  localparam logic [2:0] PLN_NEXT = 3'b000;
  localparam logic [2:0] PLN_STOP_MARK = 3'b001;
  localparam logic [2:0] PLN_STOP_NE = 3'b011;
  localparam logic [2:0] PLN_JMP = 3'b100;
  localparam logic [2:0] PLN_JMP_MARK = 3'b101;

  typedef enum logic [1:0] {
    ACT_NEXT = 2'b00,
    ACT_STOP = 2'b01,
    ACT_JUMP = 2'b10
  } fsb_act_e;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_HALT = 1'b1
  } fsb_state_e;

endpackage : fsb_pkg

// *** design/fsb_sync.sv ***
/*
  Two-flop synchroniser for pin levels entering the formatter clock.
  Assumes the inputs are levels that stay put for several clocks.
*/
module fsb_sync
  import fsb_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds the second stage only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : fsb_sync

// *** design/fsb_cond_eval.sv ***
/*
  Combinational branch evaluation: picks the command table from the
  word's select bits and the read gate, then decodes the 3-bit command
  against the crc, compare and sector-mark conditions.
  Assumes all inputs are settled in the formatter clock domain.
*/
module fsb_cond_eval
  import fsb_pkg::*;
(
  // table select
  input wire logic alt_sel,
  input wire logic proc_crc,
  input wire logic read_gate,
  // command and conditions
  input wire logic [2:0] cmd,
  input wire logic crc_err,
  input wire logic cmp_ne,
  input wire logic mark_found,
  // result
  output fsb_act_e act,
  output logic crc_table,
  output logic alt_used
);

  function automatic fsb_act_e crc_act(input logic [2:0] c,
                                       input logic e, input logic n);
    fsb_act_e a;
    a = ACT_NEXT;
    case (c)
      CRC_STOP_CRC: if (e) a = ACT_STOP;
      CRC_STOP_NE: if (n) a = ACT_STOP;
      CRC_STOP_NE_CRC: if (n || e) a = ACT_STOP;
      CRC_JMP_GOOD: if (!e && !n) a = ACT_JUMP;
      CRC_JMP_CRC: if (e) a = ACT_JUMP;
      CRC_JMP_NE: if (n) a = ACT_JUMP;
      CRC_JMP_NE_CRC: if (n || e) a = ACT_JUMP;
      default: a = ACT_NEXT;
    endcase
    return a;
  endfunction : crc_act

  function automatic fsb_act_e pln_act(input logic [2:0] c,
                                       input logic n, input logic m);
    fsb_act_e a;
    a = ACT_NEXT;
    case (c)
      PLN_NEXT: a = ACT_NEXT;
      PLN_STOP_MARK: if (m) a = ACT_STOP;
      PLN_STOP_NE: if (n) a = ACT_STOP;
      PLN_JMP: a = ACT_JUMP;
      PLN_JMP_MARK: if (m) a = ACT_JUMP;
      default: a = ACT_NEXT;
    endcase
    return a;
  endfunction : pln_act

  // alternate command set lives elsewhere; here it just continues
  always_comb begin
    alt_used = alt_sel;
    crc_table = !alt_sel && proc_crc && read_gate;
    if (alt_sel) begin
      act = ACT_NEXT;
    end else if (crc_table) begin
      act = crc_act(cmd, crc_err, cmp_ne);
    end else begin
      act = pln_act(cmd, cmp_ne, mark_found);
    end
  end

endmodule : fsb_cond_eval

// *** design/fsb_branch_decode.sv ***
/*
  Format sequencer branch decoder.  At the end of each sequencer word it
  evaluates the word's branch command and loads the next sequencer
  address, jumps to the branch address, or halts the sequencer.
  Assumes: word fields and crc/compare flags come from logic on sys_clk;
  read gate and sector-mark found arrive from pins; software uses the
  plain register port with read data one cycle after the read strobe.
*/
module fsb_branch_decode
  import fsb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // current sequencer word
  input wire logic word_done,
  input wire logic [2:0] word_cmd,
  input wire logic word_alt_sel,
  input wire logic word_proc_crc,
  input wire logic [ADDR_W-1:0] word_next_addr,
  input wire logic [DATA_W-1:0] word_branch_field,
  // datapath conditions
  input wire logic crc_error,
  input wire logic cmp_not_equal,
  // pins
  input wire logic read_gate_pin,
  input wire logic sector_mark_found,
  // register port
  input wire logic [REG_A_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // sequencer address counter
  output logic [ADDR_W-1:0] seq_addr,
  output logic seq_load,
  output logic seq_halted
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] pin_sync;
  logic read_gate;
  logic mark_found;

  fsb_sync #(
    .W(2)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({read_gate_pin, sector_mark_found}),
    .q(pin_sync)
  );

  assign read_gate = pin_sync[1];
  assign mark_found = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic hit(input logic [REG_A_W-1:0] a,
                               input logic [7:0] off);
    return a == off;
  endfunction : hit

  logic wr_br_addr;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_start;
  logic wr_halt_cnt;
  logic restart;

  always_comb begin
    wr_br_addr = 1'b0;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_start = 1'b0;
    wr_halt_cnt = 1'b0;
    if (reg_wr && hit(reg_addr, OFF_BR_ADDR)) begin
      wr_br_addr = 1'b1;
    end else if (reg_wr && hit(reg_addr, OFF_CTRL)) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && hit(reg_addr, OFF_STAT)) begin
      wr_stat = 1'b1;
    end else if (reg_wr && hit(reg_addr, OFF_START)) begin
      wr_start = 1'b1;
    end else if (reg_wr && hit(reg_addr, OFF_HALT_CNT)) begin
      wr_halt_cnt = 1'b1;
    end
  end

  // restart is a self-clearing command bit, never stored
  assign restart = wr_ctrl && reg_wdata[CTRL_RESTART_BIT];

  ////////////////////////////////////////////////////////////////////////
  // software-written registers

  logic [DATA_W-1:0] br_addr_ff;
  logic src_reg_ff;
  logic [ADDR_W-1:0] start_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      br_addr_ff <= RST_BR_ADDR;
    end else if (wr_br_addr) begin
      br_addr_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_reg_ff <= RST_CTRL[CTRL_SRC_BIT];
    end else if (wr_ctrl) begin
      src_reg_ff <= reg_wdata[CTRL_SRC_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_ff <= RST_START[ADDR_W-1:0];
    end else if (wr_start) begin
      start_ff <= reg_wdata[ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // branch evaluation

  fsb_act_e act;
  logic crc_table;
  logic alt_used;
  logic [ADDR_W-1:0] branch_target;
  logic eval;

  fsb_cond_eval u_eval (
    .alt_sel(word_alt_sel),
    .proc_crc(word_proc_crc),
    .read_gate(read_gate),
    .cmd(word_cmd),
    .crc_err(crc_error),
    .cmp_ne(cmp_not_equal),
    .mark_found(mark_found),
    .act(act),
    .crc_table(crc_table),
    .alt_used(alt_used)
  );

  // target source chosen by software, one register bit
  assign branch_target = src_reg_ff ? br_addr_ff[ADDR_W-1:0]
                                    : word_branch_field[ADDR_W-1:0];

  // a restart in the same cycle outranks the word's own branch
  fsb_state_e state_ff;
  fsb_state_e nxt_state;

  assign eval = word_done && state_ff == ST_RUN && !restart;

  ////////////////////////////////////////////////////////////////////////
  // sequencer state

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (eval && act == ACT_STOP) begin
          nxt_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (restart) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
    if (restart) begin
      nxt_state = ST_RUN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address counter load

  logic [ADDR_W-1:0] seq_addr_ff;
  logic [ADDR_W-1:0] nxt_seq_addr;
  logic seq_load_ff;
  logic seq_halted_ff;

  always_comb begin
    nxt_seq_addr = seq_addr_ff;
    if (restart) begin
      nxt_seq_addr = start_ff;
    end else if (eval && act == ACT_JUMP) begin
      nxt_seq_addr = branch_target;
    end else if (eval && act == ACT_NEXT) begin
      nxt_seq_addr = word_next_addr;
    end
  end

  // a stop leaves the address where it was
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_addr_ff <= RST_START[ADDR_W-1:0];
    end else begin
      seq_addr_ff <= nxt_seq_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_load_ff <= 1'b0;
    end else begin
      seq_load_ff <= restart || (eval && act != ACT_STOP);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_halted_ff <= 1'b0;
    end else begin
      seq_halted_ff <= nxt_state == ST_HALT;
    end
  end

  assign seq_addr = seq_addr_ff;
  assign seq_load = seq_load_ff;
  assign seq_halted = seq_halted_ff;

  ////////////////////////////////////////////////////////////////////////
  // status and history

  fsb_act_e last_act_ff;
  logic crc_tbl_ff;
  logic alt_seen_ff;
  logic [DATA_W-1:0] halt_cnt_ff;
  logic [6:0] snap_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_act_ff <= ACT_NEXT;
      crc_tbl_ff <= 1'b0;
    end else if (eval) begin
      last_act_ff <= act;
      crc_tbl_ff <= crc_table;
    end
  end

  // sticky; write one to clear, a new event wins over the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alt_seen_ff <= 1'b0;
    end else if (eval && alt_used) begin
      alt_seen_ff <= 1'b1;
    end else if (wr_stat && reg_wdata[STAT_ALT_BIT]) begin
      alt_seen_ff <= 1'b0;
    end
  end

  // halts since last clear; saturates rather than wraps
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      halt_cnt_ff <= '0;
    end else if (eval && act == ACT_STOP) begin
      if (wr_halt_cnt) begin
        halt_cnt_ff <= DATA_W'(1);
      end else if (halt_cnt_ff != '1) begin
        halt_cnt_ff <= halt_cnt_ff + DATA_W'(1);
      end
    end else if (wr_halt_cnt) begin
      halt_cnt_ff <= '0;
    end
  end

  // conditions seen by the last evaluated word, for retry firmware
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      snap_ff <= '0;
    end else if (eval) begin
      snap_ff[SNAP_CMD_LSB +: 3] <= word_cmd;
      snap_ff[SNAP_TBL_BIT] <= crc_table;
      snap_ff[SNAP_CRC_BIT] <= crc_error;
      snap_ff[SNAP_NE_BIT] <= cmp_not_equal;
      snap_ff[SNAP_MARK_BIT] <= mark_found;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;

  always_comb begin
    nxt_rdata = '0;
    if (!reg_rd) begin
      nxt_rdata = '0;
    end else if (hit(reg_addr, OFF_BR_ADDR)) begin
      nxt_rdata = br_addr_ff;
    end else if (hit(reg_addr, OFF_CTRL)) begin
      nxt_rdata[CTRL_SRC_BIT] = src_reg_ff;
    end else if (hit(reg_addr, OFF_STAT)) begin
      nxt_rdata[STAT_HALT_BIT] = state_ff == ST_HALT;
      nxt_rdata[STAT_ACT_LSB +: 2] = last_act_ff;
      nxt_rdata[STAT_CRC_TBL_BIT] = crc_tbl_ff;
      nxt_rdata[STAT_ALT_BIT] = alt_seen_ff;
    end else if (hit(reg_addr, OFF_SEQ)) begin
      nxt_rdata[ADDR_W-1:0] = seq_addr_ff;
    end else if (hit(reg_addr, OFF_START)) begin
      nxt_rdata[ADDR_W-1:0] = start_ff;
    end else if (hit(reg_addr, OFF_HALT_CNT)) begin
      nxt_rdata = halt_cnt_ff;
    end else if (hit(reg_addr, OFF_SNAP)) begin
      nxt_rdata[6:0] = snap_ff;
    end
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : fsb_branch_decode

// *** test/fsb_branch_decode_sva.sv ***
/*
  Port checker for the format sequencer branch decoder.
  Assumes the two pins reach the decoder through a two-flop synchroniser.
*/
module fsb_branch_decode_chk
  import fsb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // word and conditions
  input wire logic word_done,
  input wire logic [2:0] word_cmd,
  input wire logic word_alt_sel,
  input wire logic word_proc_crc,
  input wire logic [ADDR_W-1:0] word_next_addr,
  input wire logic [DATA_W-1:0] word_branch_field,
  input wire logic crc_error,
  input wire logic cmp_not_equal,
  input wire logic read_gate_pin,
  input wire logic sector_mark_found,
  // register port
  input wire logic [REG_A_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // sequencer
  input wire logic [ADDR_W-1:0] seq_addr,
  input wire logic seq_load,
  input wire logic seq_halted
);
  logic [1:0] rg_ff;
  logic [1:0] mk_ff;
  logic src_ff;
  logic [ADDR_W-1:0] br_ff;
  logic rs, ev, tbl, ne, ce, stp, jmp;
  logic [2:0] c;
  logic [ADDR_W-1:0] tgt;

  // mirror the pin lag so table choice matches the decoder
  always_ff @(posedge sys_clk) begin
    rg_ff <= rst ? 2'h0 : {rg_ff[0], read_gate_pin};
    mk_ff <= rst ? 2'h0 : {mk_ff[0], sector_mark_found};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_ff <= 1'b0;
      br_ff <= '0;
    end else if (reg_wr && reg_addr == OFF_CTRL) begin
      src_ff <= reg_wdata[CTRL_SRC_BIT];
    end else if (reg_wr && reg_addr == OFF_BR_ADDR) begin
      br_ff <= reg_wdata[ADDR_W-1:0];
    end
  end

  assign c = word_cmd;
  assign ne = cmp_not_equal;
  assign ce = crc_error;
  assign rs = reg_wr && reg_addr == OFF_CTRL && reg_wdata[CTRL_RESTART_BIT];
  assign ev = word_done && !seq_halted && !rs;
  assign tbl = word_proc_crc && rg_ff[1];
  assign stp = !word_alt_sel && (tbl ?
      (c == CRC_STOP_CRC && ce || c == CRC_STOP_NE && ne ||
       c == CRC_STOP_NE_CRC && (ne || ce)) :
      (c == PLN_STOP_MARK && mk_ff[1] || c == PLN_STOP_NE && ne));
  assign jmp = !word_alt_sel && (tbl ?
      (c == CRC_JMP_GOOD && !ne && !ce || c == CRC_JMP_CRC && ce ||
       c == CRC_JMP_NE && ne || c == CRC_JMP_NE_CRC && (ne || ce)) :
      (c == PLN_JMP || c == PLN_JMP_MARK && mk_ff[1]));
  assign tgt = src_ff ? br_ff : word_branch_field[ADDR_W-1:0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  property p_stop;
    ev && stp |=> seq_halted && !seq_load && seq_addr == $past(seq_addr);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt in place");
  property p_jump;
    ev && jmp |=> seq_load && !seq_halted && seq_addr == $past(tgt);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");
  property p_next;
    ev && !stp && !jmp |=> seq_load && seq_addr == $past(word_next_addr);
  endproperty
  a_next: assert property (p_next)
    else $error("next address not taken");
  property p_alt;
    ev && word_alt_sel |=> !seq_halted && seq_addr == $past(word_next_addr);
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate word left next address");
  property p_freeze;
    seq_halted && !rs |=> seq_halted && !seq_load && $stable(seq_addr);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("halted address moved");
  property p_idle;
    !word_done && !rs |=> !seq_load && $stable(seq_addr);
  endproperty
  a_idle: assert property (p_idle)
    else $error("address moved without word end");
  property p_restart;
    rs |=> !seq_halted && seq_load;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not honoured");
  property p_sticky;
    ev && stp ##1 !rs [*3] |=> seq_halted;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("halt dropped by itself");

  c_stop: cover property (ev && stp);
  c_jump: cover property (ev && jmp);
  c_wake: cover property (seq_halted && rs);
endmodule : fsb_branch_decode_chk

bind fsb_branch_decode fsb_branch_decode_chk u_chk (
  .sys_clk, .rst, .word_done, .word_cmd, .word_alt_sel, .word_proc_crc,
  .word_next_addr, .word_branch_field, .crc_error, .cmp_not_equal,
  .read_gate_pin, .sector_mark_found, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .seq_addr, .seq_load, .seq_halted
);

// *** test/fsb_seq_model.sv ***
/*
  Behavioural sequencer and crc/compare side feeding the decoder.
  Assumes the bench calls issue() once per word, from after a clock edge.
*/
module fsb_seq_model
  import fsb_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // word toward the decoder
  output logic word_done,
  output logic [2:0] word_cmd,
  output logic word_alt_sel,
  output logic word_proc_crc,
  output logic [ADDR_W-1:0] word_next_addr,
  output logic [DATA_W-1:0] word_branch_field,
  // datapath conditions
  output logic crc_error,
  output logic cmp_not_equal
);
  initial begin
    word_done = 1'b0;
    {word_cmd, word_alt_sel, word_proc_crc} = '0;
    {word_next_addr, word_branch_field} = '0;
    {crc_error, cmp_not_equal} = '0;
  end

  task automatic issue(input logic alt, pc, input logic [2:0] cmd,
                       input logic [ADDR_W-1:0] na,
                       input logic [DATA_W-1:0] bf, input logic ce, ne);
    @(posedge sys_clk);
    word_done <= 1'b1;
    {word_cmd, word_alt_sel, word_proc_crc} <= {cmd, alt, pc};
    {word_next_addr, word_branch_field} <= {na, bf};
    {crc_error, cmp_not_equal} <= {ce, ne};
    @(posedge sys_clk);
    word_done <= 1'b0;
    // fields mean nothing outside the pulse, so scramble them
    {word_cmd, word_alt_sel, word_proc_crc} <= ~{cmd, alt, pc};
    {word_next_addr, word_branch_field} <= ~{na, bf};
  endtask : issue
endmodule : fsb_seq_model

// *** test/fsb_branch_decode_tb.sv ***
/*
  Self-checking bench for the branch decoder.
  Assumes the sequencer model supplies words and the bench drives pins.
*/
module fsb_branch_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fsb_pkg::*;

  localparam logic [4:0] RA = 5'h0A;
  localparam logic [4:0] NA = 5'h13;
  localparam logic [7:0] BF = 8'hE6;
  localparam logic [7:0] BR = 8'h15;

  logic sys_clk, rst, word_done, word_alt_sel, word_proc_crc, src;
  logic crc_error, cmp_not_equal, read_gate_pin, sector_mark_found;
  logic reg_wr, reg_rd, seq_load, seq_halted;
  logic [2:0] word_cmd;
  logic [ADDR_W-1:0] word_next_addr, seq_addr;
  logic [7:0] word_branch_field, reg_addr, reg_wdata, reg_rdata;
  int errors, compares;

  fsb_branch_decode dut (
    .sys_clk, .rst, .word_done, .word_cmd, .word_alt_sel, .word_proc_crc,
    .word_next_addr, .word_branch_field, .crc_error, .cmp_not_equal,
    .read_gate_pin, .sector_mark_found, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .seq_addr, .seq_load, .seq_halted
  );
  fsb_seq_model seq_mdl (
    .sys_clk, .word_done, .word_cmd, .word_alt_sel, .word_proc_crc,
    .word_next_addr, .word_branch_field, .crc_error, .cmp_not_equal
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // three edges so the synchronised copies have settled
  task automatic pins(input logic rg, input logic mk);
    @(posedge sys_clk);
    {read_gate_pin, sector_mark_found} <= {rg, mk};
    repeat (3) @(posedge sys_clk);
  endtask : pins

  function automatic fsb_act_e exp_act(input logic alt, tbl,
      input logic [2:0] c, input logic ce, ne, mk);
    logic s, j;
    s = tbl ? (c == 3'h1 && ce || c == 3'h2 && ne || c == 3'h3 && (ne || ce))
            : (c == 3'h1 && mk || c == 3'h3 && ne);
    j = tbl ? (c == 3'h4 && !ce && !ne || c == 3'h5 && ce ||
               c == 3'h6 && ne || c == 3'h7 && (ne || ce))
            : (c == 3'h4 || c == 3'h5 && mk);
    if (alt)
      return ACT_NEXT;
    return s ? ACT_STOP : (j ? ACT_JUMP : ACT_NEXT);
  endfunction : exp_act

  // restart at a known address, present one word, judge the outcome
  task automatic run(input logic alt, pc, rg, mk, input logic [2:0] c,
                     input logic ce, ne);
    fsb_act_e e;
    logic [4:0] t;
    logic [7:0] v;
    wr(OFF_CTRL, {6'h00, 1'b1, src});
    seq_mdl.issue(alt, pc, c, NA, BF, ce, ne);
    #1;
    e = exp_act(alt, pc && rg, c, ce, ne, mk);
    t = src ? BR[4:0] : BF[4:0];
    t = e == ACT_STOP ? RA : (e == ACT_JUMP ? t : NA);
    chk(8'(seq_addr), 8'(t));
    chk(8'(seq_halted), 8'(e == ACT_STOP));
    chk(8'(seq_load), 8'(e != ACT_STOP));
    rd(OFF_STAT, v);
    v[7:4] = 4'h0;
    chk(v, {4'h0, !alt && pc && rg, 2'(e), e == ACT_STOP});
  endtask : run

  ////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] v;
    rd(OFF_CTRL, v);
    chk(v, RST_CTRL);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, v);
    chk(v, 8'h00);
    wr(OFF_BR_ADDR, BR);
    rd(OFF_BR_ADDR, v);
    chk(v, BR);
    wr(OFF_START, {3'h0, RA});
    wr(OFF_CTRL, 8'h02);
    rd(OFF_CTRL, v);
    chk(v, 8'h00);
    rd(OFF_SEQ, v);
    chk(v, {3'h0, RA});
  endtask : t_regs

  // every code under the crc and plain tables (never the alternate set) and every condition mix
  task automatic t_tables;
    for (int m = 0; m < 8; m++) begin
      pins(m[0], m[1]);
      for (int c = 0; c < 8; c++)
        for (int k = 0; k < 4; k++)
          run(1'b0, m[2], m[0], m[1], 3'(c), k[1], k[0]);
    end
  endtask : t_tables

  task automatic t_alt_src;
    logic [7:0] v;
    pins(1'b1, 1'b1);
    for (int c = 0; c < 8; c++)
      run(1'b1, 1'b1, 1'b1, 1'b1, 3'(c), 1'b1, 1'b1);
    rd(OFF_STAT, v);
    chk(8'(v[STAT_ALT_BIT]), 8'h01);
    wr(OFF_STAT, 8'h10);
    rd(OFF_STAT, v);
    chk(8'(v[STAT_ALT_BIT]), 8'h00);
    src = 1'b1;
    run(1'b0, 1'b0, 1'b1, 1'b1, 3'h4, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1'b1, 1'b1, 3'h7, 1'b1, 1'b1);
    src = 1'b0;
  endtask : t_alt_src

  task automatic t_halt;
    logic [7:0] v;
    pins(1'b0, 1'b1);
    wr(OFF_HALT_CNT, 8'h00);
    run(1'b0, 1'b0, 1'b0, 1'b1, 3'h1, 1'b0, 1'b0);
    seq_mdl.issue(1'b0, 1'b0, 3'h4, NA, BF, 1'b0, 1'b0);
    #1;
    chk({seq_halted, seq_load, 1'b0, seq_addr}, {2'b10, 1'b0, RA});
    rd(OFF_HALT_CNT, v);
    chk(v, 8'h01);
    rd(OFF_SNAP, v);
    chk(v, 8'h41);
    wr(OFF_CTRL, 8'h02);
    #1;
    chk({seq_halted, seq_load, 1'b0, seq_addr}, {2'b01, 1'b0, RA});
  endtask : t_halt

  task automatic end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    {read_gate_pin, sector_mark_found, src} = 3'b000;
    errors = 0;
    compares = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_tables();
    t_alt_src();
    t_halt();
    end_of_test();
  end

  // about 1700 cycles expected; allow well over ten times that
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule : fsb_branch_decode_tb
